// [design/dcd_bcd_chain.sv]
`timescale 1ns/100ps
`include "dcd_cfg.svh"
module dcd_bcd_chain
  import dcd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic inc,
  output dcd_count_t count,
  output logic carry_out
);
  dcd_count_t next_count;
  logic c;

  // Decimal step with carry through six digits
  always_comb begin
    next_count = count;
    c = inc;
    for (int i = 0; i < 6; i++) begin
      if (c) begin
        if (count[i] == 4'h9) begin
          next_count[i] = 4'h0;
        end else begin
          next_count[i] = count[i] + 4'h1;
          c = 1'b0;
        end
      end
    end
    if (clr) begin
      next_count = '0;
    end
  end

  assign carry_out = c & ~clr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule

// [design/dcd_counter.sv]
// Local design decisions: the address map and register access over APB.
`timescale 1ns/100ps
`include "dcd_cfg.svh"
// Functional notes
// - Accumulate mode counts events decimally with carry
// - Carry out of top digit lights overflow
// - Hold freezes display, counting continues
// - Run shows newest value, counting unbroken
// - Shortest gate gives one fractional kHz digit
// - Each longer gate adds one digit
// - Longest gate at 200 kHz overflows
// - Auto range settles without overflow
// - Reset shows all eights and decimal points
// - Auto overflow restarts at shortest gate
// - Overflow lamp on seventh slot segments
module dcd_counter
  import dcd_pkg::*;
#(
  parameter int unsigned BASE_CYC = `DCD_BASE_CYC
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic event_in,
  output dcd_disp_t disp,
  output logic [7:0] digit_slot,
  output logic [6:0] seg,
  output logic overflow_lamp
);

  ////////////////////////////////////////////////////////////////
  logic [31:0] ctrl, next_ctrl;
  logic wr_en, rd_en, addr_ok;
  logic [31:0] next_prdata;
  logic func_freq, hold, auto_mode;
  logic [1:0] man_gate;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign addr_ok = paddr == `DCD_CTRL_OFS || paddr == `DCD_STAT_OFS ||
    paddr == `DCD_COUNT_OFS || paddr == `DCD_DISP_OFS ||
    paddr == `DCD_TIME_OFS;
  assign pslverr = psel & penable & ~addr_ok;
  assign func_freq = ctrl[`DCD_CTRL_FUNC_BIT];
  assign hold = ctrl[`DCD_CTRL_HOLD_BIT];
  assign auto_mode = ctrl[`DCD_CTRL_AUTO_BIT];
  assign man_gate = ctrl[`DCD_CTRL_GATE_LSB +: 2];

  always_comb begin
    next_ctrl = ctrl;
    if (wr_en && paddr == `DCD_CTRL_OFS) begin
      next_ctrl = pwdata & 32'h0000_0037;
    end
  end

  ////////////////////////////////////////////////////////////////
  logic ev_d, ev_rise;
  logic [1:0] gate_sel, next_gate_sel;
  logic [31:0] tcnt, next_tcnt;
  logic [10:0] dec_cnt, next_dec_cnt;
  dcd_state_t state, next_state;
  dcd_count_t count;
  logic carry, ovf, next_ovf, clr_count, meas_ovf, next_meas_ovf;
  dcd_disp_t next_disp;
  logic gate_end;

  function automatic logic [10:0] gate_decades(input logic [1:0] g);
    case (g)
      2'h0: gate_decades = 11'h001;
      2'h1: gate_decades = 11'h00A;
      2'h2: gate_decades = 11'h064;
      default: gate_decades = 11'h3E8;
    endcase
  endfunction

  // Decimal point sits further left per longer gate
  function automatic logic [5:0] dp_for(input logic [1:0] g);
    dp_for = 6'h02 << g;
  endfunction

  assign ev_rise = event_in & ~ev_d;
  assign gate_end = func_freq && tcnt == BASE_CYC - 1 &&
    dec_cnt == gate_decades(gate_sel) - 11'h001;
  assign clr_count = func_freq && state == DCD_STORE;

  dcd_bcd_chain u_chain (
    .pclk(pclk),
    .presetn(presetn),
    .clr(clr_count),
    .inc(ev_rise),
    .count(count),
    .carry_out(carry)
  );

  always_comb begin
    next_state = state;
    next_tcnt = tcnt;
    next_dec_cnt = dec_cnt;
    next_gate_sel = auto_mode ? gate_sel : man_gate;
    // Entering auto from the longest manual gate must not park there
    if (auto_mode && gate_sel > `DCD_GATE_AUTO_MAX) begin
      next_gate_sel = `DCD_GATE_AUTO_MAX;
    end
    next_ovf = ovf;
    next_meas_ovf = meas_ovf;
    next_disp = disp;
    if (carry) begin
      next_ovf = 1'b1;
      next_meas_ovf = 1'b1;
    end
    case (state)
      DCD_IDLE: begin
        next_tcnt = '0;
        next_dec_cnt = '0;
        next_state = func_freq ? DCD_GATE : DCD_IDLE;
        if (!func_freq && !hold) begin
          next_disp.digits = count;
          next_disp.dp = 6'h01;
          next_disp.ovf = ovf | carry;
        end
      end
      DCD_GATE: begin
        if (!func_freq) begin
          next_state = DCD_IDLE;
        end else if (gate_end) begin
          next_state = DCD_STORE;
        end else if (tcnt == BASE_CYC - 1) begin
          next_tcnt = '0;
          next_dec_cnt = dec_cnt + 11'h001;
        end else begin
          next_tcnt = tcnt + 32'h1;
        end
      end
      DCD_STORE: begin
        next_state = DCD_GATE;
        next_tcnt = '0;
        next_dec_cnt = '0;
        next_meas_ovf = 1'b0;
        next_ovf = 1'b0;
        if (!hold) begin
          next_disp.digits = count;
          next_disp.dp = dp_for(gate_sel);
          next_disp.ovf = meas_ovf;
        end
        if (auto_mode) begin
          if (meas_ovf) begin
            next_gate_sel = `DCD_GATE_SHORT;
          end else if (gate_sel < `DCD_GATE_AUTO_MAX &&
                       count[5] == 4'h0) begin
            next_gate_sel = gate_sel + 2'h1;
          end
        end
      end
      default: next_state = DCD_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Digit multiplex over eight slots
  logic [2:0] slot, next_slot;
  logic [6:0] next_seg;

  function automatic logic [6:0] seg7(input logic [3:0] d);
    case (d)
      4'h0: seg7 = 7'h3F;
      4'h1: seg7 = 7'h06;
      4'h2: seg7 = 7'h5B;
      4'h3: seg7 = 7'h4F;
      4'h4: seg7 = 7'h66;
      4'h5: seg7 = 7'h6D;
      4'h6: seg7 = 7'h7D;
      4'h7: seg7 = 7'h07;
      4'h8: seg7 = 7'h7F;
      4'h9: seg7 = 7'h6F;
      default: seg7 = 7'h00;
    endcase
  endfunction

  always_comb begin
    next_slot = slot + 3'h1;
    next_seg = 7'h00;
    if (next_slot < 3'h6) begin
      next_seg = seg7(disp.digits[next_slot]);
    end else if (next_slot == 3'h6 && disp.ovf) begin
      // Segments b and f carry overflow in seventh slot
      next_seg = 7'h22;
    end
  end

  assign overflow_lamp = digit_slot[6] & (seg[1] | seg[5]);

  ////////////////////////////////////////////////////////////////
  always_comb begin
    next_prdata = '0;
    if (rd_en) begin
      case (paddr)
        `DCD_CTRL_OFS: next_prdata = ctrl;
        `DCD_STAT_OFS: next_prdata = {26'h0, gate_sel, 3'h0, disp.ovf};
        `DCD_COUNT_OFS: next_prdata = {8'h00, count};
        `DCD_DISP_OFS: next_prdata = {8'h00, disp.digits};
        `DCD_TIME_OFS: next_prdata = {21'h0, dec_cnt};
        default: next_prdata = '0;
      endcase
    end else begin
      next_prdata = prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `DCD_CTRL_RESET;
      prdata <= '0;
      ev_d <= 1'b0;
      state <= DCD_IDLE;
      tcnt <= '0;
      dec_cnt <= '0;
      gate_sel <= `DCD_GATE_SHORT;
      ovf <= 1'b0;
      meas_ovf <= 1'b0;
      disp <= '{ovf: 1'b1, dp: 6'h3F, digits: {6{4'h8}}};
      slot <= 3'h0;
      digit_slot <= 8'h01;
      seg <= `DCD_SEG_EIGHT;
    end else begin
      ctrl <= next_ctrl;
      prdata <= next_prdata;
      ev_d <= event_in;
      state <= next_state;
      tcnt <= next_tcnt;
      dec_cnt <= next_dec_cnt;
      gate_sel <= next_gate_sel;
      ovf <= next_ovf;
      meas_ovf <= next_meas_ovf;
      disp <= next_disp;
      slot <= next_slot;
      digit_slot <= 8'h01 << next_slot;
      seg <= next_seg;
    end
  end

  ////////////////////////////////////////////////////////////////
  property p_ovf_on_carry;
    @(posedge pclk) disable iff (!presetn)
      carry |=> ovf;
  endproperty
  a_ovf_on_carry: assert property (p_ovf_on_carry)
    else $error("overflow not set after top carry");

  property p_hold_frozen;
    @(posedge pclk) disable iff (!presetn)
      hold && $past(hold) |-> $stable(disp.digits);
  endproperty
  a_hold_frozen: assert property (p_hold_frozen)
    else $error("display changed during hold");

  property p_run_live;
    @(posedge pclk) disable iff (!presetn)
      !func_freq && !hold && state == DCD_IDLE |=>
        disp.digits == $past(count);
  endproperty
  a_run_live: assert property (p_run_live)
    else $error("display not following count in run");

  property p_lsd_step;
    @(posedge pclk) disable iff (!presetn)
      ev_rise && !clr_count && count[0] != 4'h9 |=>
        count[0] == $past(count[0]) + 4'h1;
  endproperty
  a_lsd_step: assert property (p_lsd_step)
    else $error("least digit did not step");

  property p_lsd_wrap;
    @(posedge pclk) disable iff (!presetn)
      ev_rise && !clr_count && count[0] == 4'h9 |=> count[0] == 4'h0;
  endproperty
  a_lsd_wrap: assert property (p_lsd_wrap)
    else $error("least digit did not wrap");

  property p_lamp;
    @(posedge pclk) disable iff (!presetn)
      digit_slot[6] |-> overflow_lamp == $past(disp.ovf);
  endproperty
  a_lamp: assert property (p_lamp)
    else $error("lamp not showing overflow in seventh slot");

  property p_auto_restart;
    @(posedge pclk) disable iff (!presetn)
      auto_mode && state == DCD_STORE && meas_ovf |=>
        gate_sel == `DCD_GATE_SHORT;
  endproperty
  a_auto_restart: assert property (p_auto_restart)
    else $error("auto range did not restart");

  property p_auto_cap;
    @(posedge pclk) disable iff (!presetn)
      auto_mode && $past(auto_mode) |-> gate_sel <= `DCD_GATE_AUTO_MAX;
  endproperty
  a_auto_cap: assert property (p_auto_cap)
    else $error("auto range reached longest gate");

  property p_dp_res;
    @(posedge pclk) disable iff (!presetn)
      state == DCD_STORE && !hold |=> disp.dp == dp_for($past(gate_sel));
  endproperty
  a_dp_res: assert property (p_dp_res)
    else $error("decimal point wrong for gate");

  c_overflow: cover property (@(posedge pclk) disable iff (!presetn)
    carry);
  c_store: cover property (@(posedge pclk) disable iff (!presetn)
    state == DCD_STORE);
  c_hold: cover property (@(posedge pclk) disable iff (!presetn)
    hold && ev_rise);
endmodule

// [inc/dcd_cfg.svh]
`ifndef DCD_CFG_SVH
`define DCD_CFG_SVH

// Register byte offsets
`define DCD_CTRL_OFS 12'h000
`define DCD_STAT_OFS 12'h004
`define DCD_COUNT_OFS 12'h008
`define DCD_DISP_OFS 12'h00C
`define DCD_TIME_OFS 12'h010

// Control fields
`define DCD_CTRL_FUNC_BIT 0
`define DCD_CTRL_HOLD_BIT 1
`define DCD_CTRL_AUTO_BIT 2
`define DCD_CTRL_GATE_LSB 4
`define DCD_CTRL_RESET 32'h0000_0004

// Status fields
`define DCD_STAT_OVF_BIT 0
`define DCD_STAT_GATE_LSB 4

// Gate settings and time base
`define DCD_GATE_SHORT 2'h0
`define DCD_GATE_LONG 2'h3
`define DCD_GATE_AUTO_MAX 2'h2
`define DCD_BASE_MS 10
`define DCD_CLK_KHZ 40000
`define DCD_BASE_CYC (`DCD_BASE_MS * `DCD_CLK_KHZ)

// Display patterns
`define DCD_SEG_EIGHT 7'h7F
`define DCD_BLANK_BCD 4'hF

`endif

// [inc/dcd_pkg.sv]
package dcd_pkg;
  typedef logic [3:0] dcd_digit_t;
  typedef dcd_digit_t [5:0] dcd_count_t;
  typedef struct packed {
    logic ovf;
    logic [5:0] dp;
    dcd_count_t digits;
  } dcd_disp_t;
  typedef enum logic [2:0] {
    DCD_IDLE = 3'b001,
    DCD_GATE = 3'b010,
    DCD_STORE = 3'b100
  } dcd_state_t;
endpackage

// [testbench/dcd_src.sv]
`timescale 1ns/100ps
module dcd_src (
  input wire logic pclk,
  output logic event_in
);
  logic free = 1'b0;
  int left = 0;
  initial event_in = 1'b0;
  ////////////////////////////////////////////////////////////////////////
  // One driver only, so a stop can never add a stray rising edge
  always @(posedge pclk) begin
    if (free || left != 0) begin
      event_in <= ~event_in;
      if (!free && event_in) begin
        left <= left - 1;
      end
    end else begin
      event_in <= 1'b0;
    end
  end
  task automatic send(input int n);
    @(posedge pclk);
    left <= n;
    repeat (2 * n + 2) @(posedge pclk);
  endtask
  task automatic run(input logic on);
    @(posedge pclk);
    free <= on;
  endtask
endmodule

// [testbench/testbench.sv]
`timescale 1ns/100ps
`include "dcd_cfg.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module testbench
  import dcd_pkg::*;
;
  // Short base gate keeps the longest gate inside the run budget
  localparam int unsigned BC = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, rerr;
  logic event_in, overflow_lamp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [7:0] digit_slot;
  logic [6:0] seg;
  dcd_disp_t disp;
  int miscompares = 0;
  int n_checks = 0;
  always #12.5 pclk = ~pclk;
  dcd_counter #(.BASE_CYC(BC)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_in(event_in), .disp(disp), .digit_slot(digit_slot),
    .seg(seg), .overflow_lamp(overflow_lamp));
  dcd_src src (.pclk(pclk), .event_in(event_in));
  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (miscompares == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d = 32'h0);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    // A slave that never answers counts against the run
    if (pready !== 1'b1) begin
      miscompares++;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Ends at a falling edge, where registered outputs have settled
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge pclk);
      @(negedge pclk);
      `CHK("lamp", (digit_slot == 8'h40) & disp.ovf, overflow_lamp)
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    tick(2);
    `CHK("disp", {1'b1, 6'h3F, 24'h888888}, disp)
    `CHK("seg", 7'h7F, seg)
    `CHK("slot", 8'h01, digit_slot)
    @(posedge pclk);
    presetn <= 1'b1;
    tick(2);
    `CHK("digits", 24'h000000, disp.digits)
    `CHK("ovf", 1'b0, disp.ovf)
    apb(1'b0, `DCD_CTRL_OFS);
    `CHK("ctrl", `DCD_CTRL_RESET, rdat)
    apb(1'b0, `DCD_COUNT_OFS);
    `CHK("count", 32'h0, rdat)
  endtask
  task automatic t_apb();
    apb(1'b1, `DCD_CTRL_OFS, 32'hFFFF_FFFF);
    apb(1'b0, `DCD_CTRL_OFS);
    `CHK("mask", 32'h0000_0037, rdat)
    apb(1'b0, 12'h100);
    `CHK("rd err", 1'b1, rerr)
    `CHK("rd val", 32'h0, rdat)
    apb(1'b1, 12'h100, 32'h1);
    `CHK("wr err", 1'b1, rerr)
  endtask
  task automatic t_accum();
    apb(1'b1, `DCD_CTRL_OFS, 32'h0);
    src.send(123);
    tick(3);
    `CHK("digits", 24'h000123, disp.digits)
    apb(1'b0, `DCD_COUNT_OFS);
    `CHK("count", 32'h0000_0123, rdat)
  endtask
  task automatic t_hold();
    apb(1'b1, `DCD_CTRL_OFS, 32'h2);
    src.send(5);
    tick(3);
    `CHK("frozen", 24'h000123, disp.digits)
    apb(1'b0, `DCD_COUNT_OFS);
    `CHK("live", 32'h0000_0128, rdat)
    apb(1'b1, `DCD_CTRL_OFS, 32'h0);
    tick(3);
    `CHK("run", 24'h000128, disp.digits)
    src.send(2);
    tick(3);
    `CHK("onward", 24'h000130, disp.digits)
  endtask
  task automatic t_freq();
    int sp;
    sp = BC;
    src.run(1'b1);
    for (int g = 0; g < 4; g++) begin
      apb(1'b1, `DCD_CTRL_OFS, 32'h1 | (g << `DCD_CTRL_GATE_LSB));
      tick(3 * sp + 4);
      `CHK("freq", 24'(24'h5 << (4 * g)), disp.digits)
      `CHK("dp", 6'(2 << g), disp.dp)
      `CHK("ovf", 1'b0, disp.ovf)
      apb(1'b0, `DCD_STAT_OFS);
      `CHK("gate", 2'(g), rdat[5:4])
      sp = sp * 10;
    end
    // Quiet input, so the next reset sees no events
    src.run(1'b0);
  endtask
  task automatic t_auto();
    src.run(1'b1);
    apb(1'b1, `DCD_CTRL_OFS, 32'h5);
    tick(3 * BC * 111 + 20);
    apb(1'b0, `DCD_STAT_OFS);
    `CHK("gate", 2'h2, rdat[5:4])
    `CHK("freq", 24'h000500, disp.digits)
    `CHK("dp", 6'h08, disp.dp)
    `CHK("ovf", 1'b0, disp.ovf)
    src.run(1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    t_reset();
    t_apb();
    t_accum();
    t_hold();
    t_freq();
    t_reset();
    t_auto();
    finish_test();
  end
  // Budget covers the longest gate six times over
  initial begin
    repeat (60000) @(posedge pclk);
    miscompares++;
    finish_test();
  end
endmodule
